// ### hdl/acp_adc_ctrl.sv
// Converter control and status port with a behavioural successive-approximation core
module acp_adc_ctrl #(
   parameter int CAL_CYC = acp_pkg::CAL_CYCLES
) (
   input  wire logic                          SYS_CLK,
   input  wire logic                          SYS_RST,
   input  wire logic                          CLK_EN,
   input  wire logic                          CONVERTER_RESET_IN,
   input  wire logic                          COMPARATOR_POWER_DOWN,
   input  wire logic                          CONVERSION_START,
   input  wire logic [acp_pkg::MODE_W-1:0]    MODE,
   input  wire logic [acp_pkg::CTRL_W-1:0]    CONVERTER_CLOCK_DIVIDE,
   input  wire logic [acp_pkg::CTRL_W-1:0]    SAMPLE_TIME_CONTROL,
   input  wire logic [acp_pkg::CHAN_W-1:0]    CHANNEL_SELECT,
   input  wire logic                          COMPARE_IN,
   output logic                               BUSY,
   output logic                               CALIBRATE,
   output logic                               RESULT_VALID,
   output logic                               SAMPLE,
   output logic [acp_pkg::RESULT_W-1:0]       RESULT,
   output logic [acp_pkg::CHAN_W-1:0]         MUX_CHANNEL,
   output logic                               QUAD_ENABLE,
   output logic                               COMPARATOR_ENABLE
);
   localparam int CNT_W = 16;
   if (CAL_CYC < 1 || CAL_CYC >= (1 << CNT_W)) begin : g_bad_cal
      $error("CAL_CYC out of range");
   end

   acp_pkg::acp_state_t state;
   acp_pkg::acp_state_t next_state;
   logic [CNT_W-1:0]             cnt;
   logic [acp_pkg::CTRL_W-1:0]   div_cnt;
   logic [3:0]                   bit_idx;
   logic [acp_pkg::RESULT_W-1:0] sar;

   wire hold_rst  = SYS_RST | CONVERTER_RESET_IN;
   wire div_tick  = (div_cnt == CONVERTER_CLOCK_DIVIDE);
   wire cal_done  = (cnt == CNT_W'(CAL_CYC - 1));
   wire samp_done = div_tick && (cnt[acp_pkg::CTRL_W-1:0] == SAMPLE_TIME_CONTROL);
   wire conv_done = div_tick && (bit_idx == 4'h0);
   wire start_ok  = CONVERSION_START && !COMPARATOR_POWER_DOWN;
   // Trial bit walks MSB first; lower bits start set, each step may only clear
   wire [acp_pkg::RESULT_W-1:0] bit_mask = {{(acp_pkg::RESULT_W-1){1'b0}}, 1'b1} << bit_idx;
   wire [acp_pkg::RESULT_W-1:0] sar_next = COMPARE_IN ? sar : (sar & ~bit_mask);

   always_comb begin
      next_state = state;
      case (state)
         acp_pkg::ACP_CAL:    if (COMPARATOR_POWER_DOWN) next_state = acp_pkg::ACP_OFF;
                              else if (cal_done) next_state = acp_pkg::ACP_IDLE;
         acp_pkg::ACP_IDLE:   if (COMPARATOR_POWER_DOWN) next_state = acp_pkg::ACP_OFF;
                              else if (start_ok) next_state = acp_pkg::ACP_SAMPLE;
         acp_pkg::ACP_SAMPLE: if (COMPARATOR_POWER_DOWN) next_state = acp_pkg::ACP_OFF;
                              else if (samp_done) next_state = acp_pkg::ACP_CONV;
         acp_pkg::ACP_CONV:   if (COMPARATOR_POWER_DOWN) next_state = acp_pkg::ACP_OFF;
                              else if (conv_done) next_state = acp_pkg::ACP_IDLE;
         acp_pkg::ACP_OFF:    if (!COMPARATOR_POWER_DOWN) next_state = acp_pkg::ACP_IDLE;
         default:             next_state = acp_pkg::ACP_CAL;
      endcase
   end

   // Counters reset on every state change so each phase times from zero
   always_ff @(posedge SYS_CLK) begin
      if (hold_rst) begin
         state   <= acp_pkg::ACP_CAL;
         cnt     <= '0;
         div_cnt <= '0;
         bit_idx <= 4'(acp_pkg::CONV_BITS - 1);
         sar     <= '1;
      end else if (CLK_EN) begin
         state <= next_state;
         if (next_state != state) begin
            cnt     <= '0;
            div_cnt <= '0;
            bit_idx <= 4'(acp_pkg::CONV_BITS - 1);
            if (next_state == acp_pkg::ACP_CONV)
               sar <= '1;
         end else begin
            div_cnt <= div_tick ? '0 : div_cnt + 1'b1;
            if (state == acp_pkg::ACP_CAL)
               cnt <= cnt + 1'b1;
            else if (state == acp_pkg::ACP_SAMPLE && div_tick)
               cnt <= cnt + 1'b1;
            if (state == acp_pkg::ACP_CONV && div_tick) begin
               sar     <= sar_next;
               bit_idx <= bit_idx - 1'b1;
            end
         end
      end
   end

   // Status registered from the next state so outputs align with the FSM
   always_ff @(posedge SYS_CLK) begin
      if (hold_rst) begin
         BUSY              <= 1'b0;
         CALIBRATE         <= 1'b1;
         RESULT_VALID      <= 1'b0;
         SAMPLE            <= 1'b0;
         RESULT            <= acp_pkg::RESULT_RST;
         MUX_CHANNEL       <= '0;
         QUAD_ENABLE       <= 1'b0;
         COMPARATOR_ENABLE <= 1'b0;
      end else if (CLK_EN) begin
         QUAD_ENABLE       <= 1'b1;
         COMPARATOR_ENABLE <= !COMPARATOR_POWER_DOWN;
         CALIBRATE         <= (next_state == acp_pkg::ACP_CAL);
         SAMPLE            <= (next_state == acp_pkg::ACP_SAMPLE);
         BUSY              <= (next_state == acp_pkg::ACP_SAMPLE)
                              || (next_state == acp_pkg::ACP_CONV);
         if (state == acp_pkg::ACP_IDLE && start_ok) begin
            MUX_CHANNEL  <= CHANNEL_SELECT;
            RESULT_VALID <= 1'b0;
         end
         if (state == acp_pkg::ACP_CONV && conv_done && !COMPARATOR_POWER_DOWN) begin
            RESULT       <= sar_next;
            RESULT_VALID <= 1'b1;
         end
         // Powered down: previous result no longer trusted
         if (COMPARATOR_POWER_DOWN)
            RESULT_VALID <= 1'b0;
      end
   end

   // MODE is accepted for compatibility; only one conversion mode modelled
   wire unused_mode = ^MODE;

   property p_reset_holds;
      @(posedge SYS_CLK) CONVERTER_RESET_IN |=> (CALIBRATE && !QUAD_ENABLE && !BUSY);
   endproperty
   a_reset_holds: assert property (p_reset_holds) else $error("reset not held");

   property p_pd_comp_off;
      @(posedge SYS_CLK) disable iff (hold_rst)
         (CLK_EN && COMPARATOR_POWER_DOWN) |=> !COMPARATOR_ENABLE && !BUSY;
   endproperty
   a_pd_comp_off: assert property (p_pd_comp_off) else $error("comparator still on");

   property p_pd_novalid;
      @(posedge SYS_CLK) disable iff (hold_rst)
         (CLK_EN && COMPARATOR_POWER_DOWN) |=> !RESULT_VALID;
   endproperty
   a_pd_novalid: assert property (p_pd_novalid) else $error("valid while down");

   property p_busy_state;
      @(posedge SYS_CLK) disable iff (hold_rst)
         BUSY == (state == acp_pkg::ACP_SAMPLE || state == acp_pkg::ACP_CONV);
   endproperty
   a_busy_state: assert property (p_busy_state) else $error("busy mismatch");

   property p_cal_excl;
      @(posedge SYS_CLK) disable iff (hold_rst) CALIBRATE |-> !BUSY && !RESULT_VALID;
   endproperty
   a_cal_excl: assert property (p_cal_excl) else $error("calibrate overlap");

   property p_valid_after_busy;
      @(posedge SYS_CLK) disable iff (hold_rst)
         $rose(RESULT_VALID) |-> $past(BUSY) && !BUSY;
   endproperty
   a_valid_after_busy: assert property (p_valid_after_busy) else $error("valid w/o conv");

   property p_sample_in_busy;
      @(posedge SYS_CLK) disable iff (hold_rst) SAMPLE |-> BUSY && !CALIBRATE;
   endproperty
   a_sample_in_busy: assert property (p_sample_in_busy) else $error("sample idle");

   property p_start_samples;
      @(posedge SYS_CLK) disable iff (hold_rst)
         (CLK_EN && state == acp_pkg::ACP_IDLE && start_ok)
            |=> SAMPLE && MUX_CHANNEL == $past(CHANNEL_SELECT);
   endproperty
   a_start_samples: assert property (p_start_samples) else $error("start lost");

   // Quads come back on the first enabled edge out of reset
   property p_qe_on;
      @(posedge SYS_CLK)
         (!hold_rst && CLK_EN) |=> QUAD_ENABLE;
   endproperty
   a_qe_on: assert property (p_qe_on) else $error("quads not enabled");

   property p_busy_no_cal;
      @(posedge SYS_CLK) disable iff (hold_rst)
         BUSY |-> !CALIBRATE && COMPARATOR_ENABLE && QUAD_ENABLE;
   endproperty
   a_busy_no_cal: assert property (p_busy_no_cal) else $error("busy without comparator");

   // Result and valid stand until a start, a power-down or a reset
   property p_valid_holds;
      @(posedge SYS_CLK) disable iff (hold_rst)
         (RESULT_VALID && !COMPARATOR_POWER_DOWN && !(state == acp_pkg::ACP_IDLE && start_ok))
            |=> RESULT_VALID && $stable(RESULT);
   endproperty
   a_valid_holds: assert property (p_valid_holds) else $error("valid dropped");

   property p_result_change;
      @(posedge SYS_CLK) disable iff (hold_rst)
         ($changed(RESULT) && !$past(hold_rst)) |-> $rose(RESULT_VALID);
   endproperty
   a_result_change: assert property (p_result_change) else $error("result moved");

   property p_sample_end;
      @(posedge SYS_CLK) disable iff (hold_rst)
         ($fell(SAMPLE) && !$past(COMPARATOR_POWER_DOWN) && !$past(hold_rst)) |-> BUSY && state == acp_pkg::ACP_CONV;
   endproperty
   a_sample_end: assert property (p_sample_end) else $error("sample end lost");

   property p_cal_fall;
      @(posedge SYS_CLK) disable iff (hold_rst)
         ($fell(CALIBRATE) && !$past(COMPARATOR_POWER_DOWN)) |-> !BUSY && state == acp_pkg::ACP_IDLE;
   endproperty
   a_cal_fall: assert property (p_cal_fall) else $error("calibration end wrong");

   // Clock enable low must freeze every phase counter and flag
   property p_freeze;
      @(posedge SYS_CLK) disable iff (hold_rst)
         !CLK_EN |=> $stable(state) && $stable(BUSY) && $stable(SAMPLE) && $stable(RESULT_VALID);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");

   c_cal_done:  cover property (@(posedge SYS_CLK) $fell(CALIBRATE));
   c_conv_done: cover property (@(posedge SYS_CLK) $rose(RESULT_VALID));
   c_pd:        cover property (@(posedge SYS_CLK) state == acp_pkg::ACP_OFF);
   c_abort:     cover property (@(posedge SYS_CLK) state == acp_pkg::ACP_SAMPLE && COMPARATOR_POWER_DOWN);
   c_frozen:    cover property (@(posedge SYS_CLK) !CLK_EN && BUSY);
endmodule

// ### hdl/acp_pkg.sv
// Constants and types of the converter control port
// Operation
// - Reset holds converter, disables analog quads
// - Power-down stops comparator, digital keeps running
// - Flags may be invalid while powered down
// - Busy high exactly while converting (code also holds it high while sampling, state ACP_SAMPLE)
// - Calibrate high during power-up calibration only
// - Result valid marks completed conversion result
// - Sample high only while acquiring input
package acp_pkg;
   localparam int MODE_W      = 4;
   localparam int CTRL_W      = 8;
   localparam int CHAN_W      = 5;
   localparam int RESULT_W    = 12;
   localparam int QUAD_W      = 10;
   localparam int CLK_MHZ     = 40;
   localparam int CAL_TIME_US = 10;
   localparam int CAL_CYCLES  = CAL_TIME_US * CLK_MHZ;
   localparam int CONV_BITS   = 12;
   localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;
   typedef enum logic [4:0] {
      ACP_CAL    = 5'h01,
      ACP_IDLE   = 5'h02,
      ACP_SAMPLE = 5'h04,
      ACP_CONV   = 5'h08,
      ACP_OFF    = 5'h10
   } acp_state_t;
endpackage

// ### test/acp_analog_model.sv
// Analog side model: input multiplexer and comparator
module acp_analog_model (
   input  wire logic       SYS_CLK,
   input  wire logic [4:0] MUX_CHANNEL,
   input  wire logic       QUAD_ENABLE,
   input  wire logic       COMPARATOR_ENABLE,
   output logic            COMPARE_IN
);
   logic junk;
   always_ff @(posedge SYS_CLK) junk <= (junk === 1'b1) ? 1'b0 : 1'b1;
   // Odd channels at full scale, even at ground; a dead comparator answers noise
   assign COMPARE_IN = (COMPARATOR_ENABLE && QUAD_ENABLE) ? MUX_CHANNEL[0] : junk;
endmodule

// ### test/acp_adc_ctrl_tb.sv
// Self-checking bench of the converter control port
module acp_adc_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk, rst, crst, pdn, start, cmp, busy, cal, valid, smp, quad, cen, ce;
   logic [7:0]  div, stc;
   logic [4:0]  chan, mux;
   logic [11:0] res;
   int          n_fail = 0;
   int          checks_done = 0;
   int          cycles = 0;
   acp_adc_ctrl #(.CAL_CYC(8)) dut_u (.SYS_CLK(clk), .SYS_RST(rst), .CLK_EN(ce),
      .CONVERTER_RESET_IN(crst), .COMPARATOR_POWER_DOWN(pdn), .CONVERSION_START(start),
      .MODE(4'h0), .CONVERTER_CLOCK_DIVIDE(div), .SAMPLE_TIME_CONTROL(stc),
      .CHANNEL_SELECT(chan), .COMPARE_IN(cmp), .BUSY(busy), .CALIBRATE(cal),
      .RESULT_VALID(valid), .SAMPLE(smp), .RESULT(res), .MUX_CHANNEL(mux),
      .QUAD_ENABLE(quad), .COMPARATOR_ENABLE(cen));
   acp_analog_model ana_u (.SYS_CLK(clk), .MUX_CHANNEL(mux), .QUAD_ENABLE(quad),
      .COMPARATOR_ENABLE(cen), .COMPARE_IN(cmp));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic summarize();
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         $display("[FAIL] %0t timeout", $time);
         summarize();
      end
   end
   task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wait_cal();
      for (int n = 0; n < 40 && cal !== 1'b0; n++) begin
         @(posedge clk);
         #1;
      end
      chk({quad, cal}, 12'h002, "calibration end");
   endtask
   task automatic t_conv(input logic [4:0] ch, input logic [11:0] exp);
      int s = 1;
      @(posedge clk) begin
         chan <= ch;
         start <= 1'b1;
      end
      @(posedge clk) begin
         start <= 1'b0;
         chan <= ~ch;
      end
      #1 chk({busy, smp, valid, 4'h0, mux}, {3'b110, 4'h0, ch}, "start");
      for (int n = 0; n < 200 && busy === 1'b1; n++) begin
         @(posedge clk);
         #1;
         if (smp === 1'b1) s++;
      end
      chk(12'(s), 12'((stc + 1) * (div + 1)), "sample length");
      chk({busy, smp, valid}, 12'h001, "done flags");
      chk(res, exp, "result");
   endtask
   task automatic t_pdown();
      @(posedge clk) pdn <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk({busy, valid, smp, cen}, 12'h000, "idle power down");
      @(posedge clk) pdn <= 1'b0;
      @(posedge clk) start <= 1'b1;
      @(posedge clk) start <= 1'b0;
      repeat (4) @(posedge clk);
      pdn <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk({busy, valid, smp, cen}, 12'h000, "powered down");
      @(posedge clk) pdn <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk({cal, busy, cen}, 12'h001, "power up");
   endtask
   task automatic t_creset();
      @(posedge clk) crst <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk({quad, cal, busy, valid, smp}, 12'h008, "converter reset");
      @(posedge clk) crst <= 1'b0;
      wait_cal();
   endtask
   task automatic t_freeze();
      @(posedge clk) begin
         chan <= 5'h03;
         start <= 1'b1;
      end
      @(posedge clk) begin
         start <= 1'b0;
         ce <= 1'b0;
      end
      #1 chk({busy, smp, valid}, 12'h006, "freeze start");
      repeat (20) @(posedge clk);
      #1 chk({busy, smp, valid}, 12'h006, "frozen");
      @(posedge clk) ce <= 1'b1;
      for (int n = 0; n < 200 && busy === 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      chk({busy, smp, valid}, 12'h001, "thawed done");
      chk(res, 12'hFFF, "thawed result");
   endtask
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      crst = 1'b0;
      pdn = 1'b0;
      start = 1'b0;
      div = 8'h01;
      stc = 8'h02;
      chan = 5'h00;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      #1 chk({quad, cal, busy, valid, smp}, 12'h008, "system reset");
      wait_cal();
      t_conv(5'h01, 12'hFFF);
      t_conv(5'h02, 12'h000);
      t_pdown();
      t_conv(5'h1F, 12'hFFF);
      t_creset();
      t_conv(5'h00, 12'h000);
      t_freeze();
      summarize();
   end
endmodule
